/* sltsr_defs.svh */
/*
 * Register offsets, field positions, reset values and code values of the
 * serial link test and status register bank.
 * Assumes inclusion by bare name from the design module, the checker and the bench.
 */
`ifndef SLTSR_DEFS_SVH
`define SLTSR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLTSR_ADDR_W          12
`define SLTSR_OFS_TEST        12'h205
`define SLTSR_OFS_DEVID       12'h206
`define SLTSR_OFS_COMMA       12'h207
`define SLTSR_OFS_STATUS      12'h208

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLTSR_RST_TEST        5'h00
`define SLTSR_RST_DEVID       8'h00
`define SLTSR_RST_COMMA       2'h0

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define SLTSR_ST_LINK_UP      6
`define SLTSR_ST_SYNC         5
`define SLTSR_ST_REALIGNED    4
`define SLTSR_ST_MULTIFRAME_PHASE_SET_FLAG      3
`define SLTSR_ST_SPLL         2
`define SLTSR_ST_CPLL         0

// ----------------------------------------------------------------
// Code groups and pattern seeds
// ----------------------------------------------------------------
`define SLTSR_K28_7           8'hfc
`define SLTSR_K28_1           8'h3c
`define SLTSR_K28_5           8'hbc
`define SLTSR_D21_5           8'hb5
`define SLTSR_CLK_PATTERN     16'h00ff
`define SLTSR_PRBS_SEED       31'h0000_0001

`endif

/* sltsr_pkg.sv */
/*
 * Types of the serial link test and status register bank.
 * Assumes sltsr_defs.svh is on the include path.
 */
package sltsr_pkg;

    // Lane test-select codes
    typedef enum logic [4:0] {
        SLTSR_TM_NORMAL  = 5'h00,
        SLTSR_TM_PRBS7   = 5'h01,
        SLTSR_TM_PRBS15  = 5'h02,
        SLTSR_TM_PRBS23  = 5'h03,
        SLTSR_TM_RAMP    = 5'h04,
        SLTSR_TM_TRANSP  = 5'h05,
        SLTSR_TM_D21_5   = 5'h06,
        SLTSR_TM_K28_5   = 5'h07,
        SLTSR_TM_ILA     = 5'h08,
        SLTSR_TM_RPAT    = 5'h09,
        SLTSR_TM_LOW     = 5'h0a,
        SLTSR_TM_HIGH    = 5'h0b,
        SLTSR_TM_PRBS9   = 5'h0d,
        SLTSR_TM_PRBS31  = 5'h0e,
        SLTSR_TM_CLOCK   = 5'h0f,
        SLTSR_TM_K28_7   = 5'h10
    } sltsr_test_t;

    // Lane source selected for the transmit path
    typedef enum logic [3:0] {
        SLTSR_SRC_SAMPLE = 4'h0,
        SLTSR_SRC_PRBS   = 4'h1,
        SLTSR_SRC_RAMP   = 4'h2,
        SLTSR_SRC_TRANSP = 4'h3,
        SLTSR_SRC_CODE   = 4'h4,
        SLTSR_SRC_ILA    = 4'h5,
        SLTSR_SRC_RPAT   = 4'h6,
        SLTSR_SRC_STATIC = 4'h7,
        SLTSR_SRC_CLOCK  = 4'h8
    } sltsr_src_t;

    // Link-up tracker states, Gray along the usual path
    typedef enum logic [1:0] {
        SLTSR_LS_DOWN  = 2'b00,
        SLTSR_LS_ALIGN = 2'b01,
        SLTSR_LS_UP    = 2'b11
    } sltsr_link_t;

endpackage : sltsr_pkg

/* sltsr_regs.sv */
/*
 * Serial link test-pattern selection, alignment device identifier,
 * end-of-frame comma selection and link status for a converter's
 * multi-lane serial output.
 * Assumes one 20 MHz core clock; pll locks and sync request arrive from
 * other domains and are synchronised here; link events come from logic
 * on the same clock.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "sltsr_defs.svh"

module sltsr_regs (
    // Clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_n_in,
    // Register port
    input  wire logic [`SLTSR_ADDR_W-1:0]   reg_addr_in,
    input  wire logic [7:0]                 reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [7:0]                 reg_rdata_out,
    // Link context from the core
    input  wire logic                       serial_link_enable_in,
    input  wire logic                       link_8b10b_in,
    input  wire logic                       frame_end_slot_in,
    input  wire logic                       sysref_event_in,
    input  wire logic                       sysref_realign_in,
    input  wire logic                       data_start_in,
    // Asynchronous status sources
    input  wire logic                       sync_request_n_in,
    input  wire logic                       serializer_pll_lock_in,
    input  wire logic                       converter_pll_lock_in,
    // Transmit path control
    output logic      [3:0]                 lane_src_out,
    output logic      [7:0]                 lane_code_out,
    output logic                            lane_static_level_out,
    output logic      [15:0]                lane_clock_pattern_out,
    output logic      [30:0]                prbs_state_out,
    output logic      [7:0]                 ila_device_id_out,
    output logic                            frame_end_insert_out,
    output logic      [7:0]                 frame_end_code_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Standard PRBS polynomials, Fibonacci form shifting left
    function automatic logic [30:0] prbs_step(input logic [30:0] s,
                                              input logic [4:0]  mode);
        logic fb;
        fb = 1'b0;
        case (mode)
            5'h01:   fb = s[6]  ^ s[5];   // x7+x6+1
            5'h02:   fb = s[14] ^ s[13];  // x15+x14+1
            5'h03:   fb = s[22] ^ s[17];  // x23+x18+1
            5'h0d:   fb = s[8]  ^ s[4];   // x9+x5+1
            default: fb = s[30] ^ s[27];  // x31+x28+1
        endcase
        prbs_step = {s[29:0], fb};
    endfunction : prbs_step

    function automatic logic is_prbs(input logic [4:0] code);
        is_prbs = (code == 5'h01) || (code == 5'h02) || (code == 5'h03) ||
                  (code == 5'h0d) || (code == 5'h0e);
    endfunction : is_prbs

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] async_meta_reg;
    logic [2:0] async_sync_reg;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            async_meta_reg <= 3'h0;
            async_sync_reg <= 3'h0;
        end
        else
        begin
            async_meta_reg <= {sync_request_n_in, serializer_pll_lock_in,
                               converter_pll_lock_in};
            async_sync_reg <= async_meta_reg;
        end
    end

    wire sync_deasserted     = async_sync_reg[2];
    wire serializer_pll_lock = async_sync_reg[1];
    wire converter_pll_lock  = async_sync_reg[0];

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire hit_test   = (reg_addr_in == `SLTSR_OFS_TEST);
    wire hit_devid  = (reg_addr_in == `SLTSR_OFS_DEVID);
    wire hit_comma  = (reg_addr_in == `SLTSR_OFS_COMMA);
    wire hit_status = (reg_addr_in == `SLTSR_OFS_STATUS);

    wire wr_test   = reg_wr_in && hit_test;
    wire wr_devid  = reg_wr_in && hit_devid;
    wire wr_comma  = reg_wr_in && hit_comma;
    wire wr_status = reg_wr_in && hit_status;

    logic [4:0] test_sel_reg;
    logic [7:0] device_id_reg;
    logic [1:0] comma_sel_reg;
    logic       realigned_reg;
    logic       multiframe_phase_set_flag_reg;
    logic       multiframe_phase_set_flag_armed_reg;

    // Reserved bits are not stored, so they read back as zero
    // Writes while the link runs are accepted; their effect is undefined
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            test_sel_reg  <= `SLTSR_RST_TEST;
            device_id_reg <= `SLTSR_RST_DEVID;
            comma_sel_reg <= `SLTSR_RST_COMMA;
        end
        else
        begin
            if (wr_test)
                test_sel_reg <= reg_wdata_in[4:0];
            if (wr_devid)
                device_id_reg <= reg_wdata_in;
            if (wr_comma)
                comma_sel_reg <= reg_wdata_in[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Sticky alignment flags; set wins over write-one-clear
    // ----------------------------------------------------------------
    wire clr_realigned = wr_status && reg_wdata_in[`SLTSR_ST_REALIGNED];
    wire clr_multiframe_phase_set_flag   = wr_status && reg_wdata_in[`SLTSR_ST_MULTIFRAME_PHASE_SET_FLAG];
    wire first_sysref  = serial_link_enable_in && multiframe_phase_set_flag_armed_reg &&
                         sysref_event_in;

    wire realigned_next = sysref_realign_in ||
                          (realigned_reg && !clr_realigned);
    wire multiframe_phase_set_flag_next   = first_sysref ||
                          (multiframe_phase_set_flag_reg && !clr_multiframe_phase_set_flag);

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            realigned_reg     <= 1'b0;
            multiframe_phase_set_flag_reg       <= 1'b0;
            multiframe_phase_set_flag_armed_reg <= 1'b1;
        end
        else
        begin
            realigned_reg     <= realigned_next;
            multiframe_phase_set_flag_reg       <= multiframe_phase_set_flag_next;
            // Rearm on disable so the next enable catches its first SYSREF
            multiframe_phase_set_flag_armed_reg <= !serial_link_enable_in ||
                                 (multiframe_phase_set_flag_armed_reg && !first_sysref);
        end
    end

    // ----------------------------------------------------------------
    // Link-up tracker
    // ----------------------------------------------------------------
    sltsr_pkg::sltsr_link_t link_state_reg;
    sltsr_pkg::sltsr_link_t link_state_next;

    always_comb
    begin
        link_state_next = link_state_reg;
        if (!serial_link_enable_in || !sync_deasserted)
            link_state_next = sltsr_pkg::SLTSR_LS_DOWN;
        else
            case (link_state_reg)
                sltsr_pkg::SLTSR_LS_DOWN:
                    link_state_next = sltsr_pkg::SLTSR_LS_ALIGN;
                sltsr_pkg::SLTSR_LS_ALIGN:
                    if (data_start_in)
                        link_state_next = sltsr_pkg::SLTSR_LS_UP;
                default:
                    link_state_next = sltsr_pkg::SLTSR_LS_UP;
            endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            link_state_reg <= sltsr_pkg::SLTSR_LS_DOWN;
        else
            link_state_reg <= link_state_next;
    end

    wire link_up = (link_state_reg == sltsr_pkg::SLTSR_LS_UP);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire [7:0] status_word = {1'b0, link_up, sync_deasserted,
                              realigned_reg, multiframe_phase_set_flag_reg,
                              serializer_pll_lock, 1'b0,
                              converter_pll_lock};

    logic [7:0] rdata_sel;
    always_comb
    begin
        if (hit_test)
            rdata_sel = {3'h0, test_sel_reg};
        else if (hit_devid)
            rdata_sel = device_id_reg;
        else if (hit_comma)
            rdata_sel = {6'h00, comma_sel_reg};
        else if (hit_status)
            rdata_sel = status_word;
        else
            rdata_sel = 8'h00;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 8'h00;
        else
            reg_rdata_out <= reg_rd_in ? rdata_sel : 8'h00;
    end

    // ----------------------------------------------------------------
    // Test pattern selection
    // ----------------------------------------------------------------
    // 8B/10B-only patterns fall back to sample data in 64B/66B modes
    wire only_8b10b = (test_sel_reg == sltsr_pkg::SLTSR_TM_K28_5) ||
                      (test_sel_reg == sltsr_pkg::SLTSR_TM_ILA)   ||
                      (test_sel_reg == sltsr_pkg::SLTSR_TM_RPAT)  ||
                      (test_sel_reg == sltsr_pkg::SLTSR_TM_K28_7);
    wire [4:0] eff_test = (only_8b10b && !link_8b10b_in) ?
                          5'h00 : test_sel_reg;

    sltsr_pkg::sltsr_src_t src_next;
    logic [7:0]            code_next;
    always_comb
    begin
        code_next = 8'h00;
        case (eff_test)
            5'h01, 5'h02, 5'h03, 5'h0d, 5'h0e:
                src_next = sltsr_pkg::SLTSR_SRC_PRBS;
            5'h04:   src_next = sltsr_pkg::SLTSR_SRC_RAMP;
            5'h05:   src_next = sltsr_pkg::SLTSR_SRC_TRANSP;
            5'h06:
            begin
                src_next  = sltsr_pkg::SLTSR_SRC_CODE;
                code_next = `SLTSR_D21_5;
            end
            5'h07:
            begin
                src_next  = sltsr_pkg::SLTSR_SRC_CODE;
                code_next = `SLTSR_K28_5;
            end
            5'h10:
            begin
                src_next  = sltsr_pkg::SLTSR_SRC_CODE;
                code_next = `SLTSR_K28_7;
            end
            5'h08:   src_next = sltsr_pkg::SLTSR_SRC_ILA;
            5'h09:   src_next = sltsr_pkg::SLTSR_SRC_RPAT;
            5'h0a, 5'h0b:
                src_next = sltsr_pkg::SLTSR_SRC_STATIC;
            5'h0f:   src_next = sltsr_pkg::SLTSR_SRC_CLOCK;
            // Zero and every reserved code give normal sample data
            default: src_next = sltsr_pkg::SLTSR_SRC_SAMPLE;
        endcase
    end

    // ----------------------------------------------------------------
    // PRBS generator
    // ----------------------------------------------------------------
    logic [4:0]  prbs_mode_reg;
    logic [30:0] prbs_reg;
    wire         prbs_on   = is_prbs(eff_test);
    wire         prbs_new  = prbs_on && (eff_test != prbs_mode_reg);
    wire [30:0]  prbs_next = prbs_new ? `SLTSR_PRBS_SEED :
                             prbs_on ? prbs_step(prbs_reg, eff_test) :
                             prbs_reg;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prbs_mode_reg <= 5'h00;
            prbs_reg      <= `SLTSR_PRBS_SEED;
        end
        else
        begin
            prbs_mode_reg <= eff_test;
            prbs_reg      <= prbs_next;
        end
    end

    // ----------------------------------------------------------------
    // End-of-frame comma
    // ----------------------------------------------------------------
    // Reserved selection 3 sends nothing rather than a guessed comma
    wire [7:0] comma_sel = (comma_sel_reg == 2'h1) ? `SLTSR_K28_1 :
                           (comma_sel_reg == 2'h2) ? `SLTSR_K28_5 :
                           `SLTSR_K28_7;
    wire comma_ok = (comma_sel_reg != 2'h3);

    // ----------------------------------------------------------------
    // Registered transmit controls
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            lane_src_out           <= 4'h0;
            lane_code_out          <= 8'h00;
            lane_static_level_out  <= 1'b0;
            lane_clock_pattern_out <= 16'h0000;
            ila_device_id_out      <= `SLTSR_RST_DEVID;
            frame_end_insert_out   <= 1'b0;
            frame_end_code_out     <= `SLTSR_K28_7;
        end
        else
        begin
            lane_src_out           <= src_next;
            lane_code_out          <= code_next;
            lane_static_level_out  <= (eff_test == 5'h0b);
            lane_clock_pattern_out <= `SLTSR_CLK_PATTERN;
            ila_device_id_out      <= device_id_reg;
            frame_end_insert_out   <= frame_end_slot_in && link_8b10b_in &&
                                      comma_ok;
            frame_end_code_out     <= comma_sel;
        end
    end

    assign prbs_state_out = prbs_reg;

endmodule : sltsr_regs

/* sltsr_regs_sva.sv */
/*
 * Concurrent checks on the ports of the serial link register bank.
 * Assumes it is bound to sltsr_regs and sees only that module's ports.
 */
`timescale 1ns/100ps
`include "sltsr_defs.svh"

module sltsr_regs_chk (
    // Clock, reset and register port
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic [`SLTSR_ADDR_W-1:0]   reg_addr_in,
    input  wire logic [7:0]                 reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    input  wire logic [7:0]                 reg_rdata_out,
    // Link context and transmit control
    input  wire logic                       link_8b10b_in,
    input  wire logic                       frame_end_slot_in,
    input  wire logic [3:0]                 lane_src_out,
    input  wire logic [7:0]                 lane_code_out,
    input  wire logic                       lane_static_level_out,
    input  wire logic [15:0]                lane_clock_pattern_out,
    input  wire logic [30:0]                prbs_state_out,
    input  wire logic [7:0]                 ila_device_id_out,
    input  wire logic                       frame_end_insert_out
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_static;
        lane_static_level_out |-> lane_src_out == 4'h7;
    endproperty
    a_static: assert property (p_static)
        else $error("static level without static source");
    property p_code;
        lane_src_out == 4'h4 |-> lane_code_out inside
            {`SLTSR_D21_5, `SLTSR_K28_5, `SLTSR_K28_7};
    endproperty
    a_code: assert property (p_code)
        else $error("repeated code group is not a legal one");
    // Two settled samples, since the source is registered behind the mode
    property p_8b10b;
        !link_8b10b_in && !$past(link_8b10b_in) && !$past(link_8b10b_in, 2)
        |-> !(lane_src_out inside {4'h5, 4'h6}) &&
            (lane_src_out != 4'h4 || lane_code_out == `SLTSR_D21_5);
    endproperty
    a_8b10b: assert property (p_8b10b)
        else $error("8b10b-only test pattern in 64b66b mode");
    property p_ins;
        frame_end_insert_out |-> $past(frame_end_slot_in) &&
            $past(link_8b10b_in);
    endproperty
    a_ins: assert property (p_ins)
        else $error("comma inserted outside an 8b10b frame slot");
    property p_clk;
        $past(rst_n_in) |-> lane_clock_pattern_out == `SLTSR_CLK_PATTERN;
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock test pattern wrong");
    property p_prbs;
        $past(lane_src_out) == 4'h1 && lane_src_out == 4'h1 |->
            prbs_state_out != $past(prbs_state_out) && prbs_state_out != 0;
    endproperty
    a_prbs: assert property (p_prbs)
        else $error("prbs generator stuck");
    property p_did;
        reg_wr_in && reg_addr_in == `SLTSR_OFS_DEVID |->
            ##2 ila_device_id_out == $past(reg_wdata_in, 2);
    endproperty
    a_did: assert property (p_did)
        else $error("alignment identifier not taken from register");
    property p_st_rsv;
        reg_rd_in && reg_addr_in == `SLTSR_OFS_STATUS |=>
            reg_rdata_out[7] == 1'b0 && reg_rdata_out[1] == 1'b0;
    endproperty
    a_st_rsv: assert property (p_st_rsv)
        else $error("reserved status bit reads one");
endmodule : sltsr_regs_chk

bind sltsr_regs sltsr_regs_chk u_chk (
    .core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .link_8b10b_in, .frame_end_slot_in,
    .lane_src_out, .lane_code_out, .lane_static_level_out,
    .lane_clock_pattern_out, .prbs_state_out, .ila_device_id_out,
    .frame_end_insert_out
);

/* sltsr_rx_model.sv */
/*
 * Behavioural link receiver on the far side of the lanes.
 * Assumes the core clock and reset of the register bank.
 */
`timescale 1ns/100ps

module sltsr_rx_model (
    // Clock, reset and bench control
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       resync_in,
    // Lane side
    input  wire logic       frame_end_insert_in,
    output logic            sync_request_n_out,
    output logic [7:0]      comma_count_out
);
    // Sync stays requested through reset, as a receiver not yet locked
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_request_n_out <= 1'b0;
            comma_count_out    <= 8'h00;
        end
        else
        begin
            sync_request_n_out <= !resync_in;
            comma_count_out    <= comma_count_out + 8'(frame_end_insert_in);
        end
    end
endmodule : sltsr_rx_model

/* sltsr_regs_tb_top.sv */
/*
 * Self-checking bench of the serial link register bank.
 * Assumes sltsr_defs.svh on the include path and the receiver model.
 */
`timescale 1ns/100ps
`include "sltsr_defs.svh"

module sltsr_regs_tb_top;
    logic        core_clk_in = 1'b0, rst_n_in = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, en = 1'b0, b8 = 1'b1, slot = 1'b0;
    logic        sref = 1'b0, realign = 1'b0, dstart = 1'b0, resync = 1'b0;
    logic        spll = 1'b1, cpll = 1'b1, sync_n, stat_lvl, ins;
    logic [7:0]  rdata, ccount, rv, code_out, fcode, ila_id;
    logic [3:0]  src;
    logic [15:0] clk_pat;
    logic [30:0] prbs, prbs_a;
    int          err_count = 0, n_compared = 0;

    sltsr_regs dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .serial_link_enable_in(en),
        .link_8b10b_in(b8), .frame_end_slot_in(slot),
        .sysref_event_in(sref), .sysref_realign_in(realign),
        .data_start_in(dstart), .sync_request_n_in(sync_n),
        .serializer_pll_lock_in(spll), .converter_pll_lock_in(cpll),
        .lane_src_out(src), .lane_code_out(code_out),
        .lane_static_level_out(stat_lvl), .lane_clock_pattern_out(clk_pat),
        .prbs_state_out(prbs), .ila_device_id_out(ila_id),
        .frame_end_insert_out(ins), .frame_end_code_out(fcode));
    sltsr_rx_model u_rx (
        .clk_in(core_clk_in), .rst_n_in(rst_n_in), .resync_in(resync),
        .frame_end_insert_in(ins), .sync_request_n_out(sync_n),
        .comma_count_out(ccount));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk_in);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_in);
        rd   <= 1'b0;
        #1 chk("read data", rdata, e);
    endtask : rd_reg
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    function automatic logic [3:0] exp_src(input int c, input logic k);
        case (c)
            1, 2, 3, 13, 14: exp_src = 4'h1;
            4:               exp_src = 4'h2;
            5:               exp_src = 4'h3;
            6:               exp_src = 4'h4;
            7, 16:           exp_src = k ? 4'h4 : 4'h0;
            8:               exp_src = k ? 4'h5 : 4'h0;
            9:               exp_src = k ? 4'h6 : 4'h0;
            10, 11:          exp_src = 4'h7;
            15:              exp_src = 4'h8;
            default:         exp_src = 4'h0;
        endcase
    endfunction : exp_src
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial
    begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    // Whole sequence needs about 500 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        err_count++;
        results();
    end
    initial
    begin
        repeat (16) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        tick(6);
        rd_reg(`SLTSR_OFS_TEST, 8'h00);
        rd_reg(`SLTSR_OFS_DEVID, 8'h00);
        rd_reg(`SLTSR_OFS_COMMA, 8'h00);
        rd_reg(`SLTSR_OFS_STATUS, 8'h25);
        rd_reg(12'h209, 8'h00);
        chk("clock pattern", clk_pat, 16'h00ff);
        $display("test reset values done");
        for (int k = 1; k >= 0; k--)
        begin
            @(posedge core_clk_in) b8 <= k[0];
            for (int c = 0; c < 32; c++)
            begin
                wr_reg(`SLTSR_OFS_TEST, c[7:0]);
                tick(2);
                chk("lane source", src, exp_src(c, k[0]));
                chk("lane code", code_out, c == 6 ? `SLTSR_D21_5 :
                    (c == 7 && k == 1) ? `SLTSR_K28_5 :
                    (c == 16 && k == 1) ? `SLTSR_K28_7 : 8'h00);
                chk("static level", stat_lvl, c == 11);
                rd_reg(`SLTSR_OFS_TEST, c[7:0]);
            end
        end
        wr_reg(`SLTSR_OFS_TEST, 8'h01);
        tick(5);
        prbs_a = prbs;
        chk("prbs seed", prbs_a, `SLTSR_PRBS_SEED << 4);
        wr_reg(`SLTSR_OFS_TEST, 8'h00);
        wr_reg(`SLTSR_OFS_TEST, 8'h01);
        tick(5);
        chk("prbs restart", prbs, prbs_a);
        wr_reg(`SLTSR_OFS_TEST, 8'h00);
        wr_reg(`SLTSR_OFS_DEVID, 8'ha5);
        tick(2);
        chk("ila identifier", ila_id, 8'ha5);
        rd_reg(`SLTSR_OFS_DEVID, 8'ha5);
        $display("test patterns done");
        for (int s = 0; s < 5; s++)
        begin
            wr_reg(`SLTSR_OFS_COMMA, 8'(s % 4));
            @(posedge core_clk_in) b8 <= (s < 4);
            slot <= 1'b1;
            @(posedge core_clk_in) slot <= 1'b0;
            #1 chk("comma insert", ins, s < 3);
            chk("comma code", fcode, s == 1 ? `SLTSR_K28_1 :
                s == 2 ? `SLTSR_K28_5 : `SLTSR_K28_7);
        end
        tick(2);
        chk("commas seen", ccount, 8'h03);
        wr_reg(`SLTSR_OFS_COMMA, 8'h00);
        $display("test comma done");
        @(posedge core_clk_in) realign <= 1'b1;
        @(posedge core_clk_in) realign <= 1'b0;
        en <= 1'b1;
        tick(4);
        @(posedge core_clk_in) sref <= 1'b1;
        dstart <= 1'b1;
        @(posedge core_clk_in) sref <= 1'b0;
        dstart <= 1'b0;
        tick(2);
        rd_reg(`SLTSR_OFS_STATUS, 8'h7d);
        wr_reg(`SLTSR_OFS_STATUS, 8'h18);
        @(posedge core_clk_in) sref <= 1'b1;
        @(posedge core_clk_in) sref <= 1'b0;
        tick(2);
        rd_reg(`SLTSR_OFS_STATUS, 8'h65);
        @(posedge core_clk_in) resync <= 1'b1;
        tick(5);
        rd_reg(`SLTSR_OFS_STATUS, 8'h05);
        @(posedge core_clk_in) resync <= 1'b0;
        spll <= 1'b0;
        cpll <= 1'b0;
        en   <= 1'b0;
        tick(5);
        rd_reg(`SLTSR_OFS_STATUS, 8'h20);
        $display("test status done");
        results();
    end
endmodule : sltsr_regs_tb_top
